// file: ccr_params.svh
// constants for the channel configuration register bank
// assumes inclusion by ccr_pkg and the design files, 16-bit registers
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

`define CCR_CH_BASE_ADDR   6'h10
`define CCR_CH0_RESET      16'h8001
`define CCR_CHX_RESET      16'h0001
`define CCR_RSV_MASK       16'hf3ff
`define CCR_EN_BIT         15
`define CCR_SETUP_HI       14
`define CCR_SETUP_LO       12
`define CCR_RSV_HI         11
`define CCR_RSV_LO         10
`define CCR_POS_HI         9
`define CCR_POS_LO         5
`define CCR_NEG_HI         4
`define CCR_NEG_LO         0
`define CCR_CMD_BITS       5'h08
`define CCR_DATA_BITS      5'h10
`define CCR_CMD_READ_BIT   6
`define CCR_CODE_AIN_MAX   5'h08
`define CCR_CODE_SUP_POS   5'h13
`define CCR_CODE_SUP_NEG   5'h14
`define CCR_CODE_REF_POS   5'h15
`define CCR_CODE_REF_NEG   5'h16

`endif

// file: ccr_pkg.sv
// types shared by the channel register bank and its sequencer
// assumes ccr_params.svh sits in the same folder
`include "ccr_params.svh"

package ccr_pkg;

    typedef struct packed {
        logic       channel_active_bit;
        logic [2:0] setup_pointer;
        logic [1:0] reserved;
        logic [4:0] positive_input_select;
        logic [4:0] negative_input_select;
    } ccr_cfg_t;

    typedef struct packed {
        logic [2:0] setup_pointer;
        logic [4:0] positive_input_select;
        logic [4:0] negative_input_select;
        logic       buffers_required;
        logic       input_code_bad;
    } ccr_route_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CMD,
        ST_DATA
    } ccr_port_state_t;

endpackage : ccr_pkg

// file: ccr_sequencer.sv
// channel sequencer: picks the next enabled channel on each conversion end
// assumes i_advance is a one-cycle pulse from the conversion engine, same clock
`timescale 1ns/1ps
`include "ccr_params.svh"

module ccr_sequencer #(
    parameter int NUM_CH = 16,
    parameter int IW     = $clog2(NUM_CH)
) (
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    input  wire logic              i_ce,
    input  wire logic [NUM_CH-1:0] i_enables,
    input  wire logic              i_advance,
    output logic      [IW-1:0]     o_index
);
    import ccr_pkg::*;

    logic [IW-1:0] idx_reg;
    logic [IW-1:0] idx_next;

    // ascending search from current+1 with wrap; holds when nothing enabled
    function automatic logic [IW-1:0] find_next(input logic [NUM_CH-1:0] en, input logic [IW-1:0] cur);
        logic [IW-1:0] r;
        logic          found;
        int            k;
        r     = cur;
        found = 1'b0;
        for (int s = 1; s <= NUM_CH; s++) begin
            k = (int'(cur) + s) % NUM_CH;
            if (!found && en[k]) begin
                r     = IW'(k);
                found = 1'b1;
            end
        end
        return r;
    endfunction : find_next

    always_comb begin
        idx_next = idx_reg;
        // a disabled current channel is left at once, not at the next conversion end
        if (i_advance || !i_enables[idx_reg]) begin
            idx_next = find_next(i_enables, idx_reg); // see RL3, see RL11
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            idx_reg <= '0;
        end else if (i_ce) begin
            idx_reg <= idx_next;
        end
    end

    assign o_index = idx_reg;

    a_seq_moves_on: assert property (@(posedge i_clk) disable iff (i_srst) // see RL3
        (i_ce && i_advance && i_enables[idx_reg] && ($countones(i_enables) > 1))
            |=> (idx_reg != $past(idx_reg)) && |($past(i_enables) & (NUM_CH'(1) << idx_reg)))
        else $error("sequencer did not step to another enabled channel");

    a_seq_ascending: assert property (@(posedge i_clk) disable iff (i_srst) // see RL11
        (i_ce && i_advance && i_enables[idx_reg] && (idx_reg != '1) && i_enables[idx_reg + 1'b1])
            |=> idx_reg == $past(idx_reg) + 1'b1)
        else $error("sequencer skipped the next higher enabled channel");

endmodule : ccr_sequencer

// file: ccr_channel_bank.sv
// channel configuration register bank behind the serial register port
// assumes pins i_cs_n, i_sclk, i_din arrive unsynchronised; sclk idles high,
// data sampled on rising sclk, shifted out on falling sclk
//
// Function
// RL1: channel zero register, address 10h, reset 8001h
// RL2: bit 15 enables channel, set after reset
// RL3: several enabled channels are stepped through automatically
// RL4: bits 14:12 pick one of eight setups
// RL5: chosen setup applies setup, filter, offset, gain
// RL6: host writes same setup for shared use
// RL7: bits 11:10 reserved, read zero, not writable
// RL8: bits 9:5 select positive input, reset zero
// RL9: input codes: ain0-8, supply/5, reference
// RL10: bits 4:0 select negative input, reset one
// RL11: ascending channel order, wrapping to the lowest
`timescale 1ns/1ps
`include "ccr_params.svh"

module ccr_channel_bank #(
    parameter int NUM_CH = 16,
    parameter int IW     = $clog2(NUM_CH)
) (
    input  wire logic                i_clk,
    input  wire logic                i_srst,
    input  wire logic                i_ce,
    input  wire logic                i_cs_n,
    input  wire logic                i_sclk,
    input  wire logic                i_din,
    input  wire logic                i_conv_done,
    output logic                     o_dout,
    output logic [IW-1:0]            o_channel,
    output logic                     o_converting,
    output ccr_pkg::ccr_route_t      o_route
);
    import ccr_pkg::*;

    // pin synchronisers: 0 = cs_n, 1 = sclk, 2 = din
    logic [2:0] pin_in;
    logic [2:0] pin_clean;
    assign pin_in = {i_din, i_sclk, i_cs_n};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            logic [2:0] sh_reg;
            logic       lvl_reg;
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    sh_reg  <= 3'h7;
                    lvl_reg <= 1'b1;
                end else if (i_ce) begin
                    sh_reg <= {sh_reg[1:0], pin_in[g]};
                    // a change counts only once the second and third stage agree
                    if (sh_reg[1] == sh_reg[2]) begin
                        lvl_reg <= sh_reg[2];
                    end
                end
            end
            assign pin_clean[g] = lvl_reg;
        end
    endgenerate

    logic sclk_prev_reg;
    logic sclk_rise;
    logic sclk_fall;
    assign sclk_rise = pin_clean[1] && !sclk_prev_reg;
    assign sclk_fall = !pin_clean[1] && sclk_prev_reg;

    // serial port state
    ccr_port_state_t st_reg,   st_next;
    logic [4:0]      cnt_reg,  cnt_next;
    logic [15:0]     rx_reg,   rx_next;
    logic [15:0]     tx_reg,   tx_next;
    logic [5:0]      addr_reg, addr_next;
    logic            rd_reg,   rd_next;
    logic            dout_reg, dout_next;

    // register storage
    ccr_cfg_t        ch_reg  [NUM_CH];
    ccr_cfg_t        ch_next [NUM_CH];
    logic [NUM_CH-1:0] enables;
    logic            wr_stb;
    logic [IW-1:0]   wr_idx;
    logic            addr_hit;
    logic [15:0]     rd_data;
    logic [15:0]     rx_shifted;

    generate
        for (g = 0; g < NUM_CH; g++) begin : g_en
            assign enables[g] = ch_reg[g].channel_active_bit; // see RL2
        end
    endgenerate

    assign rx_shifted = {rx_reg[14:0], pin_clean[2]};
    assign addr_hit   = (addr_reg >= `CCR_CH_BASE_ADDR) &&
                        (32'(addr_reg - `CCR_CH_BASE_ADDR) < NUM_CH);
    assign wr_idx     = IW'(addr_reg - `CCR_CH_BASE_ADDR);

    always_comb begin
        rd_data = 16'h0000;
        // unmapped addresses read as zero
        if (rx_shifted[5:0] >= `CCR_CH_BASE_ADDR && 32'(rx_shifted[5:0] - `CCR_CH_BASE_ADDR) < NUM_CH) begin
            rd_data = ch_reg[IW'(rx_shifted[5:0] - `CCR_CH_BASE_ADDR)] & `CCR_RSV_MASK; // see RL7
        end
    end

    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        rx_next   = rx_reg;
        tx_next   = tx_reg;
        addr_next = addr_reg;
        rd_next   = rd_reg;
        dout_next = dout_reg;
        wr_stb    = 1'b0;
        if (pin_clean[0]) begin
            st_next   = ST_IDLE;
            cnt_next  = 5'h00;
            dout_next = 1'b1;
        end else begin
            if (st_reg == ST_IDLE) begin
                st_next = ST_CMD;
            end
            if (sclk_rise) begin
                rx_next  = rx_shifted;
                cnt_next = cnt_reg + 5'h01;
                case (st_reg)
                    ST_IDLE, ST_CMD: begin
                        if (cnt_reg + 5'h01 == `CCR_CMD_BITS) begin
                            addr_next = rx_shifted[5:0];
                            rd_next   = rx_shifted[`CCR_CMD_READ_BIT];
                            tx_next   = rd_data;
                            st_next   = ST_DATA;
                            cnt_next  = 5'h00;
                        end
                    end
                    ST_DATA: begin
                        if (cnt_reg + 5'h01 == `CCR_DATA_BITS) begin
                            wr_stb   = !rd_reg && addr_hit;
                            st_next  = ST_CMD;
                            cnt_next = 5'h00;
                        end
                    end
                    default: begin
                        st_next = ST_IDLE;
                    end
                endcase
            end
            if (sclk_fall && st_reg == ST_DATA && rd_reg) begin
                dout_next = tx_reg[15];
                tx_next   = {tx_reg[14:0], 1'b0};
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            ch_next[i] = ch_reg[i];
        end
        if (wr_stb) begin
            // reserved field is forced to zero whatever the host sends
            ch_next[wr_idx] = rx_shifted & `CCR_RSV_MASK; // see RL7, see RL4, see RL8, see RL10
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_reg        <= ST_IDLE;
            cnt_reg       <= 5'h00;
            rx_reg        <= 16'h0000;
            tx_reg        <= 16'h0000;
            addr_reg      <= 6'h00;
            rd_reg        <= 1'b0;
            dout_reg      <= 1'b1;
            sclk_prev_reg <= 1'b1;
            ch_reg[0]     <= `CCR_CH0_RESET; // see RL1, see RL2
            for (int i = 1; i < NUM_CH; i++) begin
                ch_reg[i] <= `CCR_CHX_RESET;
            end
        end else if (i_ce) begin
            st_reg        <= st_next;
            cnt_reg       <= cnt_next;
            rx_reg        <= rx_next;
            tx_reg        <= tx_next;
            addr_reg      <= addr_next;
            rd_reg        <= rd_next;
            dout_reg      <= dout_next;
            sclk_prev_reg <= pin_clean[1];
            for (int i = 0; i < NUM_CH; i++) begin
                ch_reg[i] <= ch_next[i];
            end
        end
    end

    // sequencing and routing to the conversion engine
    logic [IW-1:0] seq_idx;
    ccr_sequencer #(
        .NUM_CH (NUM_CH),
        .IW     (IW)
    ) u_seq (
        .i_clk     (i_clk),
        .i_srst    (i_srst),
        .i_ce      (i_ce),
        .i_enables (enables),
        .i_advance (i_conv_done), // see RL3
        .o_index   (seq_idx)
    );

    ccr_cfg_t   cur_cfg;
    ccr_route_t route_next;
    ccr_route_t route_reg;
    logic [IW-1:0] chan_reg;
    logic       conv_reg;
    assign cur_cfg = ch_reg[seq_idx];

    // true when a code names a real input
    function automatic logic code_ok(input logic [4:0] c);
        return (c <= `CCR_CODE_AIN_MAX) || (c >= `CCR_CODE_SUP_POS && c <= `CCR_CODE_REF_NEG); // see RL9
    endfunction : code_ok

    function automatic logic needs_buf(input logic [4:0] c);
        return (c == `CCR_CODE_SUP_POS) || (c == `CCR_CODE_SUP_NEG); // see RL9
    endfunction : needs_buf

    always_comb begin
        // setup index selects setup, filter, offset and gain as one group
        route_next.setup_pointer         = cur_cfg.setup_pointer; // see RL5, see RL4
        route_next.positive_input_select = cur_cfg.positive_input_select; // see RL8
        route_next.negative_input_select = cur_cfg.negative_input_select; // see RL10
        route_next.buffers_required      = needs_buf(cur_cfg.positive_input_select) ||
                                           needs_buf(cur_cfg.negative_input_select);
        route_next.input_code_bad        = !code_ok(cur_cfg.positive_input_select) ||
                                           !code_ok(cur_cfg.negative_input_select);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            route_reg <= '0;
            chan_reg  <= '0;
            conv_reg  <= 1'b0;
        end else if (i_ce) begin
            route_reg <= route_next;
            chan_reg  <= seq_idx;
            conv_reg  <= |enables;
        end
    end

    assign o_route      = route_reg;
    assign o_channel    = chan_reg;
    assign o_converting = conv_reg;
    assign o_dout       = dout_reg;

    a_reset_value: assert property (@(posedge i_clk) // see RL1
        i_srst |=> (ch_reg[0] == 16'h8001) && o_dout)
        else $error("channel zero register not at reset value");

    a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_srst) // see RL7
        (i_ce && st_reg != ST_DATA && st_next == ST_DATA) |=> (tx_reg[11:10] == 2'b00) && (ch_reg[0][11:10] == 2'b00))
        else $error("reserved bits not zero");

    a_write_lands: assert property (@(posedge i_clk) disable iff (i_srst) // see RL4
        (i_ce && wr_stb) |=> ch_reg[$past(wr_idx)] == ($past(rx_shifted) & 16'hf3ff))
        else $error("register write did not land");

    a_enable_drives: assert property (@(posedge i_clk) disable iff (i_srst) // see RL2
        i_ce |=> o_converting == $past(|enables))
        else $error("converting flag does not follow enable bits");

    a_route_follows: assert property (@(posedge i_clk) disable iff (i_srst) // see RL5
        i_ce |=> (o_route.setup_pointer == $past(cur_cfg.setup_pointer)) &&
                 (o_channel == $past(seq_idx)))
        else $error("setup routing does not follow current channel");

    a_pos_neg_route: assert property (@(posedge i_clk) disable iff (i_srst) // see RL8
        i_ce |=> (o_route.positive_input_select == $past(cur_cfg.positive_input_select)) &&
                 (o_route.negative_input_select == $past(cur_cfg.negative_input_select)))
        else $error("input routing does not follow current channel");

    a_buffer_flag: assert property (@(posedge i_clk) disable iff (i_srst) // see RL9
        (i_ce && (cur_cfg.positive_input_select == 5'h13)) |=> o_route.buffers_required)
        else $error("supply divider selected without buffer request");

    a_neg_reset: assert property (@(posedge i_clk) // see RL10
        (i_srst ##1 (!i_srst && i_ce)) |=> (o_route.negative_input_select == 5'h01))
        else $error("negative input select not one after reset");

endmodule : ccr_channel_bank

// file: ccr_host_model.sv
// host controller model for the serial register port of the channel bank
// assumes sclk idles high, device samples on rising sclk and shifts out on falling
`timescale 1ns/1ps

module ccr_host_model #(
    parameter int HALF = 6
) (
    input  wire logic i_clk,
    input  wire logic i_dout,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_din
);

    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_din  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    // raw frame, no masking; fewer than 16 data bits aborts the frame
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdata, input int nbits,
                        output logic [15:0] rdata);
        logic [23:0] sh;
        sh    = {cmd, wdata};
        rdata = 16'h0000;
        o_cs_n = 1'b0;
        tick(HALF);
        for (int i = 0; i < 8 + nbits; i++) begin
            o_sclk = 1'b0;
            o_din  = sh[23 - i];
            tick(HALF);
            o_sclk = 1'b1;
            // half period of 6 clk covers the device's ~5 clk filter delay
            if (i >= 8) begin
                rdata = {rdata[14:0], i_dout};
            end
            tick(HALF);
        end
        o_cs_n = 1'b1;
        // released data line must not keep a stale level
        o_din  = ~o_din;
        tick(2 * HALF);
    endtask : xfer

    task automatic wr(input logic [5:0] addr, input logic [15:0] data);
        logic [15:0] unused;
        xfer({2'b00, addr}, data & 16'hf3ff, 16, unused);
    endtask : wr

    task automatic rd(input logic [5:0] addr, output logic [15:0] data);
        xfer({2'b01, addr}, 16'h0000, 16, data);
    endtask : rd

endmodule : ccr_host_model

// file: tb.sv
// self-checking bench for the channel configuration register bank
// assumes ccr_pkg compiled first and ccr_host_model driving the serial pins
`timescale 1ns/1ps

module tb;
    import ccr_pkg::*;

    logic        clk;
    logic        srst;
    logic        ce;
    logic        conv_done;
    logic        cs_n;
    logic        sclk;
    logic        din;
    logic        dout;
    logic        converting;
    logic [3:0]  channel;
    ccr_route_t  route;
    logic [15:0] rdata;
    logic [4:0]  codes [8];
    int          miscompares;
    int          tests_run;

    initial clk = 1'b0;
    always #20 clk = ~clk;

    ccr_channel_bank #(.NUM_CH(16)) u_dut (
        .i_clk       (clk),
        .i_srst      (srst),
        .i_ce        (ce),
        .i_cs_n      (cs_n),
        .i_sclk      (sclk),
        .i_din       (din),
        .i_conv_done (conv_done),
        .o_dout      (dout),
        .o_channel   (channel),
        .o_converting(converting),
        .o_route     (route)
    );

    ccr_host_model u_host (
        .i_clk (clk),
        .i_dout(dout),
        .o_cs_n(cs_n),
        .o_sclk(sclk),
        .o_din (din)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // one conversion end, channel output settles two edges later
    task automatic step(input logic [3:0] exp);
        conv_done = 1'b1;
        tick(1);
        conv_done = 1'b0;
        tick(3);
        check({12'h000, channel}, {12'h000, exp}, "channel step");
    endtask : step

    function automatic logic is_buf(input logic [4:0] c);
        return c == 5'h13 || c == 5'h14;
    endfunction : is_buf

    function automatic logic is_bad(input logic [4:0] c);
        return (c > 5'h08 && c < 5'h13) || c > 5'h16;
    endfunction : is_bad

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        summarize();
    end

    initial begin
        srst      = 1'b1;
        ce        = 1'b1;
        conv_done = 1'b0;
        miscompares = 0;
        tests_run   = 0;
        codes = '{5'h00, 5'h08, 5'h09, 5'h13, 5'h14, 5'h15, 5'h16, 5'h1f};
        tick(10);
        srst = 1'b0;
        tick(6);
        check({15'h0000, converting}, 16'h0001, "active after reset");
        check({12'h000, channel}, 16'h0000, "channel after reset");
        check({1'b0, route}, 16'h0004, "route after reset");
        u_host.rd(6'h10, rdata);
        check(rdata, 16'h8001, "ch0 reset value");
        u_host.rd(6'h11, rdata);
        check(rdata, 16'h0001, "ch1 reset value");
        // host breaks the reserved-bit rule on purpose here
        u_host.xfer(8'h10, 16'hffff, 16, rdata);
        u_host.rd(6'h10, rdata);
        check(rdata, 16'hf3ff, "reserved bits read zero");
        u_host.xfer(8'h10, 16'h0000, 10, rdata);
        u_host.rd(6'h10, rdata);
        check(rdata, 16'hf3ff, "aborted frame no write");
        u_host.wr(6'h20, 16'h9fff);
        u_host.rd(6'h20, rdata);
        check(rdata, 16'h0000, "unmapped reads zero");
        for (int i = 0; i < 8; i++) begin
            u_host.wr(6'h10, {1'b1, 3'(i), 2'b00, codes[i], codes[7 - i]});
            u_host.rd(6'h10, rdata);
            check(rdata, {1'b1, 3'(i), 2'b00, codes[i], codes[7 - i]}, "field readback");
            check({1'b0, route}, {1'b0, 3'(i), codes[i], codes[7 - i], is_buf(codes[i]) | is_buf(codes[7 - i]),
                  is_bad(codes[i]) | is_bad(codes[7 - i])}, "route");
        end
        // all active channels share setup 1
        u_host.wr(6'h10, 16'h9001);
        u_host.wr(6'h11, 16'h9001);
        u_host.wr(6'h13, 16'h9001);
        u_host.wr(6'h15, 16'h9001);
        step(4'h1);
        step(4'h3);
        step(4'h5);
        step(4'h0);
        ce        = 1'b0;
        conv_done = 1'b1;
        tick(1);
        conv_done = 1'b0;
        tick(3);
        ce = 1'b1;
        check({12'h000, channel}, 16'h0000, "frozen without enable");
        u_host.wr(6'h10, 16'h1001);
        tick(4);
        check({12'h000, channel}, 16'h0001, "skip disabled channel");
        u_host.wr(6'h11, 16'h1001);
        u_host.wr(6'h13, 16'h1001);
        u_host.wr(6'h15, 16'h1001);
        tick(4);
        check({15'h0000, converting}, 16'h0000, "none enabled");
        // second reset in mid-run restores the written register
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        tick(6);
        check({12'h000, channel}, 16'h0000, "channel after second reset");
        check({15'h0000, converting}, 16'h0001, "active after second reset");
        u_host.rd(6'h10, rdata);
        check(rdata, 16'h8001, "ch0 value after second reset");
        summarize();
    end

endmodule : tb
